// ===== rtl/ubr_rate_gen.sv
/*
  Serial port rate generator for the variable-rate modes: timer 1
  overflow, timer 2 in baud mode, or the dedicated prescaled timer.
  Assumes timer 1 runs outside and hands in its overflow as a pulse,
  and that control bits from other registers arrive as levels.
*/
//
// Function
// - timer1 rate: overflow times doubler over 32
// - timer1 accepted in any mode or source
// - doubler clear: auto-reload timer1 gives fcore/(384*(256-reload))
// - timer2 needs sixteen overflows per bit
// - timer2 counts every two core clocks
// - either select bit enables timer2 baud mode
// - transmit and receive sources chosen independently
// - timer2 rate fcore/(32*(65536-reload))
// - dedicated enable overrides doubler and selects
// - enable clear: conventional timer1/timer2 rates
// - prescale field divides by two-to-the-code
// - dedicated timer replaces timer1 and timer2
// - dedicated rate 2fcore/(div*(fraction+64))
//
module ubr_rate_gen (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // register writes and read-back
  input  wire logic       ctrl_wr,
  input  wire logic       frac_wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rate_timer_control,
  output logic      [7:0] fractional_rate_value,
  // conventional rate controls
  input  wire logic       rate_doubler_bit,
  input  wire logic       transmit_rate_from_timer2,
  input  wire logic       receive_rate_from_timer2,
  input  wire logic       timer2_run,
  input  wire logic [7:0] timer2_reload_high,
  input  wire logic [7:0] timer2_reload_low,
  input  wire logic       timer1_overflow,
  // timer 2 state
  output logic            timer2_overflow,
  output logic [15:0]     timer2_count,
  // ticks to the shift logic
  output logic            tx_sample_tick,
  output logic            tx_bit_tick,
  output logic            rx_sample_tick,
  output logic            rx_bit_tick
);
  import ubr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;       // dedicated timer control
    logic [7:0]  frac;       // fractional rate value
    logic        t1_half;    // halves timer1 overflows
    logic        t2_phase;   // timer2 two-cycle prescale
    logic [15:0] t2_cnt;     // timer2 counter
    logic        t2_ov;      // timer2 overflow pulse
    logic [6:0]  pre_cnt;    // dedicated binary prescaler
    logic [8:0]  acc;        // dedicated fractional accumulator
    logic        tx_tick;    // transmit sample tick
    logic        rx_tick;    // receive sample tick
  } ubr_state_t;

  ubr_state_t st_reg;
  ubr_state_t st_next;

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  logic       ded_en;
  ubr_div_t   div_code;
  logic [6:0] pre_top;
  logic [8:0] modulus;
  logic [8:0] acc_sum;
  logic       t2_mode;
  logic       tx_from_t2;
  logic       rx_from_t2;
  logic       t1_tick;
  logic       t2_tick;
  logic       ded_tick;
  logic       pre_tick;

  // control fields, enable overrides the conventional selects
  always_comb begin
    ded_en     = st_reg.ctrl[CTRL_EN_BIT];
    div_code   = st_reg.ctrl[CTRL_DIV_MSB:CTRL_DIV_LSB];
    pre_top    = 7'((8'h01 << div_code) - 8'h01);
    modulus    = 9'(st_reg.frac) + FRAC_BASE;
    acc_sum    = st_reg.acc + FRAC_STEP;
    t2_mode    = !ded_en && (transmit_rate_from_timer2 ||
                             receive_rate_from_timer2);
    tx_from_t2 = !ded_en && transmit_rate_from_timer2;
    rx_from_t2 = !ded_en && receive_rate_from_timer2;
    // at or past the top, so lowering the code never waits for a wrap
    pre_tick   = ded_en && (st_reg.pre_cnt >= pre_top);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.t2_ov = 1'b0;
    t1_tick       = 1'b0;
    t2_tick       = 1'b0;
    ded_tick      = 1'b0;

    // register writes, reserved bits dropped
    if (ctrl_wr) begin
      st_next.ctrl = wdata & CTRL_WR_MASK;
    end
    if (frac_wr) begin
      st_next.frac = wdata;
    end

    // timer1 path: any timer1 mode; halved unless doubler set
    if (timer1_overflow && !ded_en) begin
      if (rate_doubler_bit) begin
        t1_tick = 1'b1;
      end else begin
        st_next.t1_half = !st_reg.t1_half;
        t1_tick         = st_reg.t1_half;
      end
    end

    // timer2 baud mode: one count per two core clocks
    if (t2_mode && timer2_run) begin
      st_next.t2_phase = !st_reg.t2_phase;
      if (st_reg.t2_phase) begin
        if (st_reg.t2_cnt == T2_TOP) begin
          st_next.t2_cnt = {timer2_reload_high,
                            timer2_reload_low};
          st_next.t2_ov  = 1'b1;
        end else begin
          st_next.t2_cnt = st_reg.t2_cnt + 16'h0001;
        end
      end
    end else begin
      st_next.t2_phase = 1'b0;
    end
    t2_tick = st_reg.t2_ov;

    // dedicated timer: binary prescale then fractional accumulator
    if (ded_en) begin
      if (pre_tick) begin
        st_next.pre_cnt = 7'h00;
        if (acc_sum >= modulus) begin
          st_next.acc = acc_sum - modulus;
          ded_tick    = 1'b1;
        end else begin
          st_next.acc = acc_sum;
        end
      end else begin
        st_next.pre_cnt = st_reg.pre_cnt + 7'h01;
      end
    end else begin
      st_next.pre_cnt = 7'h00;
      st_next.acc     = 9'h000;
    end

    // per-direction source selection
    if (ded_en) begin
      st_next.tx_tick = ded_tick;
      st_next.rx_tick = ded_tick;
    end else begin
      st_next.tx_tick = tx_from_t2 ? t2_tick : t1_tick;
      st_next.rx_tick = rx_from_t2 ? t2_tick : t1_tick;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg      <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.frac <= FRAC_RESET;
      st_reg.t2_cnt <= T2_TOP;   // first baud cycle reloads at once
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // sixteen sample ticks make one bit
  // ---------------------------------------------------------------
  ubr_tick_if tx_if ();
  ubr_tick_if rx_if ();

  assign tx_if.sample_tick = st_reg.tx_tick;
  assign rx_if.sample_tick = st_reg.rx_tick;

  // transmit bit divider
  ubr_bit_div #(
    .RATIO   (SAMPLES_PER_BIT)
  ) u_tx_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (tx_if.div)
  );

  // receive bit divider
  ubr_bit_div #(
    .RATIO   (SAMPLES_PER_BIT)
  ) u_rx_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (rx_if.div)
  );

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign rate_timer_control    = st_reg.ctrl;
  assign fractional_rate_value = st_reg.frac;
  assign timer2_overflow       = st_reg.t2_ov;
  assign timer2_count          = st_reg.t2_cnt;
  assign tx_sample_tick        = st_reg.tx_tick;
  assign rx_sample_tick        = st_reg.rx_tick;
  assign tx_bit_tick           = tx_if.bit_tick;
  assign rx_bit_tick           = rx_if.bit_tick;

endmodule : ubr_rate_gen

// ===== inc/ubr_pkg.sv
/*
  Constants for the serial rate generator: control register layout,
  reset values, divider figures.
  Assumes a single core clock domain and an active-low async reset.
*/
package ubr_pkg;

  // ---------------------------------------------------------------
  // control register layout
  // ---------------------------------------------------------------
  localparam int          CTRL_EN_BIT    = 7;       // dedicated timer enable
  localparam int          CTRL_DIV_MSB   = 2;       // prescale field msb
  localparam int          CTRL_DIV_LSB   = 0;       // prescale field lsb
  localparam logic [7:0]  CTRL_WR_MASK   = 8'h87;   // bits 6..3 reserved
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  FRAC_RESET     = 8'h00;

  // ---------------------------------------------------------------
  // divider figures
  // ---------------------------------------------------------------
  localparam int          SAMPLES_PER_BIT = 16;     // ticks per bit
  localparam logic [8:0]  FRAC_BASE      = 9'h040;  // added to fraction
  localparam logic [8:0]  FRAC_STEP      = 9'h020;  // accumulator step
  localparam logic [15:0] T2_TOP         = 16'hFFFF; // timer 2 overflow

  typedef logic [2:0] ubr_div_t;

endpackage : ubr_pkg

// ===== inc/ubr_tick_if.sv
/*
  Carrier between the rate generator and its per-direction bit divider.
  Assumes both ends sit on the same core clock.
*/
interface ubr_tick_if;
  logic sample_tick;   // one pulse per 1/16 bit
  logic bit_tick;      // one pulse per bit

  modport src (output sample_tick, input  bit_tick);
  modport div (input  sample_tick, output bit_tick);
endinterface : ubr_tick_if

// ===== rtl/ubr_bit_div.sv
/*
  Divides the sample tick of one direction down to the bit tick.
  Assumes sample_tick is a one-cycle pulse from a flip-flop.
*/
module ubr_bit_div #(
  parameter int RATIO = ubr_pkg::SAMPLES_PER_BIT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // tick carrier
  ubr_tick_if.div  tick
);
  import ubr_pkg::*;

  localparam int CW = $clog2(RATIO);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          bit_tick;
  } ubr_div_state_t;

  ubr_div_state_t st_reg;
  ubr_div_state_t st_next;

  // -------------------------------------------------------------
  // count sample ticks, pulse once per RATIO of them
  // -------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.bit_tick = 1'b0;
    if (tick.sample_tick) begin
      if (st_reg.cnt == CW'(RATIO - 1)) begin
        st_next.cnt      = '0;
        st_next.bit_tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + CW'(1);
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick.bit_tick = st_reg.bit_tick;

endmodule : ubr_bit_div

// ===== test/ubr_rate_gen_sva.sv
/* rate generator port checker.
   bound to ubr_rate_gen; sees its ports only. */
module ubr_rate_gen_sva
  import ubr_pkg::*;
(
  // clock, reset, registers
  input wire logic        ref_clk, resetn, ctrl_wr, frac_wr,
  input wire logic [7:0]  wdata, rate_timer_control,
  input wire logic [7:0]  fractional_rate_value,
  // rate controls
  input wire logic        rate_doubler_bit, transmit_rate_from_timer2,
  input wire logic        receive_rate_from_timer2, timer1_overflow,
  input wire logic [7:0]  timer2_reload_high, timer2_reload_low,
  // timer 2 and ticks
  input wire logic        timer2_overflow, tx_sample_tick, tx_bit_tick,
  input wire logic        rx_sample_tick,
  input wire logic [15:0] timer2_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // helper logic and properties
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic       en;
  logic [3:0] cnt_reg, cnt_next;
  logic [15:0] rl;
  assign en = rate_timer_control[CTRL_EN_BIT];
  assign rl = {timer2_reload_high, timer2_reload_low};
  // sample ticks since the last bit
  always_comb cnt_next = cnt_reg + {3'h0, tx_sample_tick};
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_next;
  end
  property p_ctrl_wr;
    ctrl_wr |=> rate_timer_control == ($past(wdata) & CTRL_WR_MASK);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr)
    else $error("control write mismatch");
  property p_frac_wr;
    frac_wr |=> fractional_rate_value == $past(wdata);
  endproperty
  a_frac_wr: assert property (p_frac_wr)
    else $error("fraction write mismatch");
  property p_t1;
    timer1_overflow && rate_doubler_bit && !en && !ctrl_wr &&
      !transmit_rate_from_timer2 |=> tx_sample_tick;
  endproperty
  a_t1: assert property (p_t1)
    else $error("timer 1 tick missing");
  property p_t2;
    timer2_overflow && !en && transmit_rate_from_timer2 |=> tx_sample_tick;
  endproperty
  a_t2: assert property (p_t2)
    else $error("timer 2 tick missing");
  property p_rx_off;
    timer2_overflow && !en && !timer1_overflow &&
      !receive_rate_from_timer2 |=> !rx_sample_tick;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receive tick from wrong source");
  property p_t2_ld;
    timer2_overflow |-> timer2_count == $past(rl);
  endproperty
  a_t2_ld: assert property (p_t2_ld)
    else $error("timer 2 reload mismatch");
  property p_t2_half;
    !$stable(timer2_count) && !timer2_overflow |=> $stable(timer2_count);
  endproperty
  a_t2_half: assert property (p_t2_half)
    else $error("timer 2 counts too fast");
  property p_bit;
    tx_bit_tick |-> cnt_reg == 4'h0 && $past(tx_sample_tick);
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit tick out of step");
endmodule : ubr_rate_gen_sva

bind ubr_rate_gen ubr_rate_gen_sva i_sva (
  .ref_clk(ref_clk), .resetn(resetn), .ctrl_wr(ctrl_wr),
  .frac_wr(frac_wr), .wdata(wdata), .timer2_count(timer2_count),
  .rate_timer_control(rate_timer_control),
  .fractional_rate_value(fractional_rate_value),
  .rate_doubler_bit(rate_doubler_bit),
  .transmit_rate_from_timer2(transmit_rate_from_timer2),
  .receive_rate_from_timer2(receive_rate_from_timer2),
  .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
  .timer2_reload_high(timer2_reload_high),
  .timer2_reload_low(timer2_reload_low),
  .tx_sample_tick(tx_sample_tick), .tx_bit_tick(tx_bit_tick),
  .rx_sample_tick(rx_sample_tick));

// ===== test/ubr_shift_model.sv
/* shift logic stand-in: tallies ticks and tick spacing.
   assumes ticks are one-cycle pulses on ref_clk. */
module ubr_shift_model (
  // clock and ticks
  input wire logic ref_clk, tx_sample_tick, tx_bit_tick,
  input wire logic rx_sample_tick, rx_bit_tick,
  // tallies for the bench
  output int       tx_n, rx_n, tx_bn, rx_bn, tx_gap, rx_gap
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0, tx_last = 0, rx_last = 0;
  // ---------------------------------------------------------------
  // tally ticks as the shift logic would see them
  // ---------------------------------------------------------------
  initial {tx_n, rx_n, tx_bn, rx_bn, tx_gap, rx_gap} = '0;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    tx_bn <= tx_bn + int'(tx_bit_tick);
    rx_bn <= rx_bn + int'(rx_bit_tick);
    if (tx_sample_tick) begin
      tx_gap <= cyc - tx_last;
      tx_last <= cyc;
      tx_n <= tx_n + 1;
    end
    if (rx_sample_tick) begin
      rx_gap <= cyc - rx_last;
      rx_last <= cyc;
      rx_n <= rx_n + 1;
    end
  end
endmodule : ubr_shift_model

// ===== test/uart_baud_rate_generator_test.sv
/* self-checking bench for the rate generator.
   assumes the checker is bound and the model tallies ticks. */
module uart_baud_rate_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ubr_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, ctrl_wr = 1'b0, frac_wr = 1'b0;
  logic dbl = 1'b0, tx_sel = 1'b0, rx_sel = 1'b0, t2_run = 1'b0;
  logic t1_ovf = 1'b0, tx_s, tx_b, rx_s, rx_b, t2_ovf;
  logic [7:0] wdata = 8'h00, rl_hi = 8'h00, rl_lo = 8'h00, ctrl, frac;
  int tx_n, rx_n, tx_bn, rx_bn, tx_gap, rx_gap;
  int bad_count = 0, checks_done = 0, cyc = 0;
  // ---------------------------------------------------------------
  // clock, design, partner, shared tasks
  // ---------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  ubr_rate_gen i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .ctrl_wr(ctrl_wr),
    .frac_wr(frac_wr), .wdata(wdata), .rate_timer_control(ctrl),
    .fractional_rate_value(frac), .rate_doubler_bit(dbl),
    .transmit_rate_from_timer2(tx_sel), .receive_rate_from_timer2(rx_sel),
    .timer2_run(t2_run), .timer2_reload_high(rl_hi),
    .timer2_reload_low(rl_lo), .timer1_overflow(t1_ovf),
    .timer2_overflow(t2_ovf), .timer2_count(), .tx_sample_tick(tx_s),
    .tx_bit_tick(tx_b), .rx_sample_tick(rx_s), .rx_bit_tick(rx_b));
  ubr_shift_model i_model (
    .ref_clk(ref_clk), .tx_sample_tick(tx_s), .tx_bit_tick(tx_b),
    .rx_sample_tick(rx_s), .rx_bit_tick(rx_b), .tx_n(tx_n),
    .rx_n(rx_n), .tx_bn(tx_bn), .rx_bn(rx_bn), .tx_gap(tx_gap),
    .rx_gap(rx_gap));
  task end_sim;
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_reg
  task chk_num(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_num
  // one register write, strobe held for one edge
  task wr(input logic c, input logic [7:0] d);
    @(negedge ref_clk);
    ctrl_wr = c;
    frac_wr = !c;
    wdata = d;
    @(negedge ref_clk);
    ctrl_wr = 1'b0;
    frac_wr = 1'b0;
  endtask : wr
  task t_regs;
    chk_reg(ctrl, CTRL_RESET);
    chk_reg(frac, FRAC_RESET);
    wr(1'b1, 8'hFF);
    chk_reg(ctrl, 8'h87);
    wr(1'b0, 8'h5A);
    chk_reg(frac, 8'h5A);
    wr(1'b1, 8'h00);
  endtask : t_regs
  // auto-reload timer 1 with reload 0xFF overflows every 12 cycles
  task t_reload;
    dbl = 1'b1;
    repeat (4) begin
      repeat (11) @(negedge ref_clk);
      t1_ovf = 1'b1;
      @(negedge ref_clk);
      t1_ovf = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
    chk_num(tx_gap, 12 * (256 - 'hFF));
  endtask : t_reload
  // back-to-back timer 1 overflows, interrupt service left out
  task t_timer1(input logic d, input int exp_s);
    int s0, r0, b0, tb0;
    s0 = tx_n;
    r0 = rx_n;
    b0 = rx_bn;
    tb0 = tx_bn;
    dbl = d;
    repeat (32) @(negedge ref_clk) t1_ovf = 1'b1;
    @(negedge ref_clk) t1_ovf = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_num(tx_n - s0, exp_s);
    chk_num(rx_n - r0, exp_s);
    chk_num(rx_bn - b0, exp_s / 16);
    chk_num(tx_bn - tb0, exp_s / 16);
  endtask : t_timer1
  task t_timer2;
    int r0;
    rl_hi = 8'hFF;
    rl_lo = 8'hF0;
    t2_run = 1'b1;
    tx_sel = 1'b1;
    r0 = tx_n;
    while (tx_n == r0) @(negedge ref_clk);
    r0 = rx_n;
    repeat (100) @(negedge ref_clk);
    chk_num(tx_gap, 2 * (65536 - 'hFFF0));
    chk_num(rx_n, r0);
    rx_sel = 1'b1;
    tx_sel = 1'b0;
    repeat (100) @(negedge ref_clk);
    chk_num(rx_gap, 32);
  endtask : t_timer2
  task t_ded(input logic [2:0] d, input logic [7:0] f, input int gap);
    wr(1'b0, f);
    wr(1'b1, 8'h80 | {5'h00, d});
    repeat (4 * gap + 8) @(negedge ref_clk);
    chk_num(tx_gap, gap);
    chk_num(rx_gap, gap);
  endtask : t_ded
  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    t_regs;
    t_reload;
    t_timer1(1'b1, 32);
    t_timer1(1'b0, 16);
    t_timer2;
    dbl = 1'b1;
    tx_sel = 1'b1;
    for (int d = 0; d < 8; d++) t_ded(d[2:0], 8'h00, 2 << d);
    t_ded(3'h0, 8'h40, 4);
    end_sim;
  end
endmodule : uart_baud_rate_generator_test
